// >>> logic/tfi_pkg.sv
// package of offsets, fields and reset values for the trip flag and interrupt block
package tfi_pkg;
   localparam logic [3:0] ADDR_SOURCE_SELECT = 4'h0;
   localparam logic [3:0] ADDR_OUTPUT_ACTION = 4'h1;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
   localparam logic [3:0] ADDR_STATUS_FLAGS = 4'h3;
   localparam logic [3:0] ADDR_FLAG_CLEAR = 4'h4;
   localparam logic [3:0] ADDR_SOFT_FORCE = 4'h5;
   localparam logic [3:0] ADDR_TRIP_STATE = 4'h6;
   localparam int BIT_INT = 0;
   localparam int BIT_PERIOD = 1;
   localparam int BIT_ONE_SHOT = 2;
   localparam int SEL_ONE_SHOT_LSB = 8;
   localparam int SEL_PERIOD_LSB = 0;
   localparam int NUM_FAULTS = 6;
   localparam logic [15:0] RESET_ZERO16 = 16'h0000;
   localparam logic [1:0] ACT_HIGH_Z = 2'h0;
   localparam logic [1:0] ACT_DRIVE_HIGH = 2'h1;
   localparam logic [1:0] ACT_DRIVE_LOW = 2'h2;
   localparam logic [1:0] ACT_NONE = 2'h3;
endpackage

// >>> logic/tfi_trip_flags.sv
// trip status flags, trip interrupt pulse and output override for one pwm channel
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// What this block does
// [R1] one-shot event pulses interrupt when its enable set
// [R2] per-period event pulses interrupt when its enable set
// [R3] one-shot flag set by selected fault input
// [R4] per-period flag set by selected fault input
// [R5] per-period flag stays until software clears it
// [R6] clear during live fault sets flag again
// [R7] per-period trip released at zero count if fault gone
// [R8] release only at zero count, whenever flag cleared
// [R9] interrupt flag set whenever pulse issued
// [R10] set interrupt flag blocks further pulses
// [R11] clearing interrupt flag with trip flag pending repulses
// [R12] software clears all three flags to stop interrupts
// [R13] flags cleared only through the clear register
// [R14] clear bits: one clears, zero ignored, read zero
// [R15] six faults, each with one-shot and per-period enable
// [R16] output action codes: hi-z, high, low, none
// [R17] force bits create trip events, read zero
// [R18] one-shot trip stays latched past zero count
// [R19] enables and flags reset zero, reserved read zero
module tfi_trip_flags
   import tfi_pkg::*;
#(
   parameter int COUNT_WIDTH = 16
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [15:0] reg_rdata_out,
   // fault pins, active low, asynchronous
   input wire logic [NUM_FAULTS-1:0] fault_n_in,
   // time base
   input wire logic [COUNT_WIDTH-1:0] time_base_count_in,
   // outputs
   output logic trip_irq_pulse_out,
   output logic trip_active_out,
   output logic [1:0] out_a_trip_action_out,
   output logic [1:0] out_b_trip_action_out,
   output logic out_a_force_out,
   output logic out_a_oe_n_out,
   output logic out_b_force_out,
   output logic out_b_oe_n_out
);

   typedef struct packed {
      logic [NUM_FAULTS-1:0] sync1;
      logic [NUM_FAULTS-1:0] sync2;
      logic [NUM_FAULTS-1:0] sync3;
      logic [NUM_FAULTS-1:0] fault;
      logic [NUM_FAULTS-1:0] sel_one_shot;
      logic [NUM_FAULTS-1:0] sel_period;
      logic [3:0] action;
      logic en_one_shot;
      logic en_period;
      logic flag_one_shot;
      logic flag_period;
      logic flag_int;
      logic trip_period;
      logic irq;
      logic [15:0] rdata;
   } tfi_state_t;

   tfi_state_t state_reg;
   tfi_state_t state_next;

   logic wr_clear;
   logic wr_force;
   logic one_shot_event;
   logic period_event;
   logic period_fault_live;
   logic zero_count;
   logic pulse_cause;
   logic trip_any;
   logic [15:0] rd_mux;

   always_comb
   begin
      wr_clear = reg_write_in && (reg_addr_in == ADDR_FLAG_CLEAR);
      wr_force = reg_write_in && (reg_addr_in == ADDR_SOFT_FORCE);
      zero_count = (time_base_count_in == '0);
      // synchronised faults are active high: a one means a fault
      period_fault_live = |(state_reg.fault & state_reg.sel_period); // [R15]
      one_shot_event = |(state_reg.fault & state_reg.sel_one_shot) ||
                       (wr_force && reg_wdata_in[BIT_ONE_SHOT]); // [R17]
      period_event = period_fault_live || (wr_force && reg_wdata_in[BIT_PERIOD]); // [R17]

      state_next = state_reg;
      state_next.sync1 = ~fault_n_in;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      // a change counts only once the last two stages agree
      for (int i = 0; i < NUM_FAULTS; i++)
      begin
         if (state_reg.sync2[i] == state_reg.sync3[i])
         begin
            state_next.fault[i] = state_reg.sync3[i];
         end
      end

      if (reg_write_in)
      begin
         case (reg_addr_in)
            ADDR_SOURCE_SELECT:
            begin
               state_next.sel_one_shot = reg_wdata_in[SEL_ONE_SHOT_LSB +: NUM_FAULTS]; // [R15]
               state_next.sel_period = reg_wdata_in[SEL_PERIOD_LSB +: NUM_FAULTS]; // [R15]
            end
            ADDR_OUTPUT_ACTION:
            begin
               state_next.action = reg_wdata_in[3:0];
            end
            ADDR_IRQ_ENABLE:
            begin
               state_next.en_one_shot = reg_wdata_in[BIT_ONE_SHOT];
               state_next.en_period = reg_wdata_in[BIT_PERIOD];
            end
            default:
            begin
               // status writes ignored: flags only cleared via clear register
               state_next.action = state_reg.action; // [R13]
            end
         endcase
      end

      // clears first, then sets so an event in the clearing cycle wins
      if (wr_clear && reg_wdata_in[BIT_ONE_SHOT])
      begin
         state_next.flag_one_shot = 1'b0; // [R14]
      end
      if (wr_clear && reg_wdata_in[BIT_PERIOD])
      begin
         state_next.flag_period = 1'b0; // [R5]
      end
      if (wr_clear && reg_wdata_in[BIT_INT])
      begin
         state_next.flag_int = 1'b0; // [R14]
      end
      if (one_shot_event)
      begin
         state_next.flag_one_shot = 1'b1; // [R3]
      end
      if (period_event)
      begin
         state_next.flag_period = 1'b1; // [R4] [R6]
      end

      // per-period trip held until a zero count with no live fault
      if (period_event)
      begin
         state_next.trip_period = 1'b1;
      end
      else if (zero_count && !period_fault_live)
      begin
         state_next.trip_period = 1'b0; // [R7] [R8]
      end

      // pulse sources: new enabled events, or pending flags after int clear
      pulse_cause = (one_shot_event && state_reg.en_one_shot) || // [R1]
                    (period_event && state_reg.en_period) || // [R2]
                    (state_next.flag_int == 1'b0 && state_reg.flag_int &&
                     ((state_next.flag_one_shot && state_reg.en_one_shot) ||
                      (state_next.flag_period && state_reg.en_period))); // [R11]
      // a pulse may only leave while the interrupt flag is clear
      state_next.irq = pulse_cause && !state_next.flag_int; // [R10]
      if (state_next.irq)
      begin
         state_next.flag_int = 1'b1; // [R9]
      end

      rd_mux = RESET_ZERO16;
      case (reg_addr_in)
         ADDR_SOURCE_SELECT:
         begin
            rd_mux[SEL_ONE_SHOT_LSB +: NUM_FAULTS] = state_reg.sel_one_shot;
            rd_mux[SEL_PERIOD_LSB +: NUM_FAULTS] = state_reg.sel_period;
         end
         ADDR_OUTPUT_ACTION:
         begin
            rd_mux[3:0] = state_reg.action;
         end
         ADDR_IRQ_ENABLE:
         begin
            rd_mux[BIT_ONE_SHOT] = state_reg.en_one_shot;
            rd_mux[BIT_PERIOD] = state_reg.en_period;
         end
         ADDR_STATUS_FLAGS:
         begin
            rd_mux[BIT_ONE_SHOT] = state_reg.flag_one_shot;
            rd_mux[BIT_PERIOD] = state_reg.flag_period;
            rd_mux[BIT_INT] = state_reg.flag_int;
         end
         ADDR_TRIP_STATE:
         begin
            rd_mux[BIT_ONE_SHOT] = state_reg.flag_one_shot;
            rd_mux[BIT_PERIOD] = state_reg.trip_period;
         end
         default:
         begin
            // clear and force read zero, unmapped too
            rd_mux = RESET_ZERO16; // [R14] [R17] [R19]
         end
      endcase
      state_next.rdata = reg_read_in ? rd_mux : RESET_ZERO16;
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_reg <= '0; // [R19]
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // one-shot trip is never released by the counter
   assign trip_any = state_reg.flag_one_shot || state_reg.trip_period; // [R18]

   always_comb
   begin
      out_a_trip_action_out = state_reg.action[1:0];
      out_b_trip_action_out = state_reg.action[3:2];
      out_a_force_out = 1'b0;
      out_a_oe_n_out = 1'b0;
      out_b_force_out = 1'b0;
      out_b_oe_n_out = 1'b0;
      if (trip_any)
      begin
         // [R16]
         case (state_reg.action[1:0])
            ACT_HIGH_Z: out_a_oe_n_out = 1'b1;
            ACT_DRIVE_HIGH: out_a_force_out = 1'b1;
            ACT_DRIVE_LOW: out_a_force_out = 1'b1;
            default: out_a_force_out = 1'b0;
         endcase
         case (state_reg.action[3:2])
            ACT_HIGH_Z: out_b_oe_n_out = 1'b1;
            ACT_DRIVE_HIGH: out_b_force_out = 1'b1;
            ACT_DRIVE_LOW: out_b_force_out = 1'b1;
            default: out_b_force_out = 1'b0;
         endcase
      end
   end

   assign trip_irq_pulse_out = state_reg.irq;
   assign trip_active_out = trip_any;
   assign reg_rdata_out = state_reg.rdata;

   property p_int_flag_follows_pulse;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         trip_irq_pulse_out |-> state_reg.flag_int;
   endproperty
   a_int_flag_follows_pulse: assert property (p_int_flag_follows_pulse) else $error("pulse without flag"); // [R9]

   property p_no_pulse_while_flag;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         trip_irq_pulse_out |-> !$past(state_reg.flag_int) || $past(wr_clear && reg_wdata_in[BIT_INT]);
   endproperty
   a_no_pulse_while_flag: assert property (p_no_pulse_while_flag) else $error("pulse while flag set"); // [R10]

   property p_one_shot_pulse;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         (wr_force && reg_wdata_in[BIT_ONE_SHOT] && state_reg.en_one_shot && !state_reg.flag_int)
            |=> trip_irq_pulse_out;
   endproperty
   a_one_shot_pulse: assert property (p_one_shot_pulse) else $error("one-shot force gave no pulse"); // [R1]

   property p_period_pulse;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         (wr_force && reg_wdata_in[BIT_PERIOD] && state_reg.en_period && !state_reg.flag_int)
            |=> trip_irq_pulse_out;
   endproperty
   a_period_pulse: assert property (p_period_pulse) else $error("per-period force gave no pulse"); // [R2]

   property p_no_enable_no_pulse;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         (!state_reg.en_one_shot && !state_reg.en_period &&
          !$past(state_reg.en_one_shot) && !$past(state_reg.en_period))
            |-> !trip_irq_pulse_out;
   endproperty
   a_no_enable_no_pulse: assert property (p_no_enable_no_pulse) else $error("pulse with both enables off"); // [R1]

   property p_one_shot_set;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         one_shot_event |=> state_reg.flag_one_shot;
   endproperty
   a_one_shot_set: assert property (p_one_shot_set) else $error("one-shot flag not set"); // [R3]

   property p_period_relatch;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         period_fault_live |=> state_reg.flag_period && state_reg.trip_period;
   endproperty
   a_period_relatch: assert property (p_period_relatch) else $error("per-period flag not held under fault"); // [R6]

   property p_release_at_zero;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         ($past(state_reg.trip_period) && !state_reg.trip_period) |-> $past(zero_count);
   endproperty
   a_release_at_zero: assert property (p_release_at_zero) else $error("trip released off zero"); // [R8]

   property p_one_shot_held;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         (state_reg.flag_one_shot && !(wr_clear && reg_wdata_in[BIT_ONE_SHOT])) |=> state_reg.flag_one_shot;
   endproperty
   a_one_shot_held: assert property (p_one_shot_held) else $error("one-shot flag dropped"); // [R18]
endmodule

// >>> verification/tfi_fault_src.sv
// far-side model: fault pins, time-base counter, interrupt pulse counter
`timescale 1ns/1ps
module tfi_fault_src #(
   parameter int PERIOD = 32
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // bench control
   input wire logic [5:0] fault_in,
   input wire logic run_in,
   input wire logic irq_in,
   // toward the block
   output logic [5:0] fault_n_out,
   output logic [15:0] count_out,
   output int irq_count_out
);
   // pins are active low, so an idle fault reads high
   assign fault_n_out = ~fault_in;
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         count_out <= 16'h0001;
         irq_count_out <= 0;
      end
      else
      begin
         if (run_in)
            count_out <= (count_out == 16'(PERIOD - 1)) ? 16'h0000 : count_out + 16'h0001;
         if (irq_in)
            irq_count_out <= irq_count_out + 1;
      end
   end
endmodule

// >>> verification/tfi_trip_flags_tb.sv
// self-checking bench of the trip flag and interrupt block
`timescale 1ns/1ps
module tfi_trip_flags_tb;
   import tfi_pkg::*;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [5:0] fault = 6'h00;
   logic run = 1'b0;
   logic [15:0] rdata, count, rd;
   logic [5:0] fault_n;
   logic irq, active, a_f, a_oe, b_f, b_oe;
   logic [1:0] a_act, b_act;
   logic m_shot = 1'b0;
   logic m_period = 1'b0;
   logic m_int = 1'b0;
   logic [15:0] m_en = 16'h0000;
   int irq_count, k, pin;
   int n_mismatch = 0;
   int samples_checked = 0;
   int exp_irq = 0;
   always #4 ref_clk_in = ~ref_clk_in;
   tfi_fault_src #(.PERIOD(32)) far (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .fault_in(fault),
      .run_in(run), .irq_in(irq), .fault_n_out(fault_n), .count_out(count), .irq_count_out(irq_count));
   tfi_trip_flags uut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata),
      .fault_n_in(fault_n), .time_base_count_in(count), .trip_irq_pulse_out(irq), .trip_active_out(active),
      .out_a_trip_action_out(a_act), .out_b_trip_action_out(b_act), .out_a_force_out(a_f),
      .out_a_oe_n_out(a_oe), .out_b_force_out(b_f), .out_b_oe_n_out(b_oe));
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
   begin
      @(posedge ref_clk_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge ref_clk_in);
      wr_s <= 1'b0;
   end
   endtask
   task automatic rdr(input logic [3:0] a);
   begin
      @(posedge ref_clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk_in);
      rd_s <= 1'b0;
      #1 rd = rdata;
   end
   endtask
   // model: an enabled event pulses only while the interrupt flag is clear
   task automatic ev(input logic o, input logic c);
   begin
      m_shot |= o;
      m_period |= c;
      if (!m_int && ((o && m_en[2]) || (c && m_en[1])))
      begin
         m_int = 1'b1;
         exp_irq++;
      end
   end
   endtask
   task automatic clr(input logic [2:0] b);
   begin
      if (b[2])
         m_shot = 1'b0;
      if (b[1])
         m_period = 1'b0;
      if (b[0])
      begin
         m_int = 1'b0;
         ev(m_shot, m_period);
      end
   end
   endtask
   task automatic state();
   begin
      repeat (3) @(posedge ref_clk_in);
      rdr(ADDR_STATUS_FLAGS);
      chk("status", {13'h0, m_shot, m_period, m_int}, rd);
      chk("irq_pulses", 16'(exp_irq), 16'(irq_count));
   end
   endtask
   // counter stops one step past the target, so a zero target leaves it nonzero
   task automatic run_to(input logic [15:0] v);
   begin
      run <= 1'b1;
      for (k = 0; k < 100 && count !== v; k++)
         @(posedge ref_clk_in);
      if (k == 100)
      begin
         n_mismatch++;
         wrap_up();
      end
      run <= 1'b0;
   end
   endtask
   task automatic wrap_up();
   begin
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk_in);
      n_mismatch++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(45202));
      repeat (8) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      for (int a = 0; a < 16; a++)
      begin
         rdr(4'(a));
         chk("reset_value", 16'h0000, rd);
      end
      wr(ADDR_SOURCE_SELECT, 16'hffff);
      rdr(ADDR_SOURCE_SELECT);
      chk("select_mask", 16'h3f3f, rd);
      wr(ADDR_OUTPUT_ACTION, 16'hffff);
      rdr(ADDR_OUTPUT_ACTION);
      chk("action_mask", 16'h000f, rd);
      wr(ADDR_IRQ_ENABLE, 16'hffff);
      rdr(ADDR_IRQ_ENABLE);
      chk("enable_mask", 16'h0006, rd);
      wr(ADDR_SOURCE_SELECT, 16'h0000);
      wr(ADDR_IRQ_ENABLE, 16'h0004);
      m_en = 16'h0004;
      wr(ADDR_STATUS_FLAGS, 16'h0007);
      state();
      wr(ADDR_SOFT_FORCE, 16'h0004);
      ev(1'b1, 1'b0);
      state();
      wr(ADDR_SOFT_FORCE, 16'h0002);
      ev(1'b0, 1'b1);
      state();
      wr(ADDR_FLAG_CLEAR, 16'h0001);
      clr(3'h1);
      state();
      wr(ADDR_FLAG_CLEAR, 16'h0000);
      state();
      rdr(ADDR_SOFT_FORCE);
      chk("force_read", 16'h0000, rd);
      for (int c = 0; c < 4; c++)
      begin
         wr(ADDR_OUTPUT_ACTION, 16'(c * 5));
         repeat (2) @(posedge ref_clk_in);
         chk("override", {8'h0, c == 0, c == 1 || c == 2, c == 0, c == 1 || c == 2, 2'(c), 2'(c)},
            {8'h0, a_oe, a_f, b_oe, b_f, a_act, b_act});
      end
      run_to(16'h0000);
      state();
      rdr(ADDR_TRIP_STATE);
      chk("trip_state", 16'h0004, rd);
      wr(ADDR_FLAG_CLEAR, 16'h0007);
      clr(3'h7);
      state();
      chk("active", 16'h0000, {15'h0, active});
      pin = $urandom_range(5, 0);
      wr(ADDR_SOURCE_SELECT, 16'(1 << pin));
      fault <= 6'(1 << pin);
      repeat (6) @(posedge ref_clk_in);
      ev(1'b0, 1'b1);
      state();
      wr(ADDR_FLAG_CLEAR, 16'h0002);
      state();
      @(posedge ref_clk_in);
      fault <= 6'h00;
      state();
      wr(ADDR_FLAG_CLEAR, 16'h0002);
      clr(3'h2);
      state();
      rdr(ADDR_TRIP_STATE);
      chk("held_off_zero", 16'h0002, rd);
      chk("active_held", 16'h0001, {15'h0, active});
      run_to(16'h0000);
      rdr(ADDR_TRIP_STATE);
      chk("released_at_zero", 16'h0000, rd);
      // one-shot with its enable off, then an enabled per-period force
      wr(ADDR_IRQ_ENABLE, 16'h0002);
      m_en = 16'h0002;
      wr(ADDR_SOFT_FORCE, 16'h0004);
      ev(1'b1, 1'b0);
      state();
      wr(ADDR_SOFT_FORCE, 16'h0002);
      ev(1'b0, 1'b1);
      state();
      // one-shot from a pin, kept past the zero count
      wr(ADDR_FLAG_CLEAR, 16'h0007);
      clr(3'h7);
      wr(ADDR_IRQ_ENABLE, 16'h0004);
      m_en = 16'h0004;
      wr(ADDR_SOURCE_SELECT, 16'(1 << (pin + 8)));
      fault <= 6'(1 << pin);
      repeat (6) @(posedge ref_clk_in);
      ev(1'b1, 1'b0);
      state();
      @(posedge ref_clk_in);
      fault <= 6'h00;
      run_to(16'h0000);
      rdr(ADDR_TRIP_STATE);
      chk("one_shot_kept", 16'h0004, rd);
      wr(ADDR_FLAG_CLEAR, 16'h0001);
      clr(3'h1);
      state();
      wrap_up();
   end
endmodule
